// ---- spfc_pkg.sv ----
// Shared constants and carrier types for the self-programming flash control block.
package spfc_pkg;
   localparam int unsigned CLK_MHZ          = 250;
   localparam int unsigned OP_MIN_US        = 3700;
   localparam int unsigned OP_MAX_US        = 4500;
   // Least time rounds up; one tick of the timer is one mclk cycle.
   localparam int unsigned OP_MIN_CYC       = OP_MIN_US * CLK_MHZ;
   localparam int unsigned OP_MAX_CYC       = OP_MAX_US * CLK_MHZ;
   localparam int unsigned SPM_WINDOW       = 4;
   localparam int unsigned LPM_WINDOW       = 3;

   localparam logic [7:0]  CSR_ADDR         = 8'h00;
   localparam logic [7:0]  LOCK_ADDR        = 8'h01;
   localparam logic [7:0]  FUSE_LO_ADDR     = 8'h02;
   localparam logic [7:0]  FUSE_HI_ADDR     = 8'h03;
   localparam logic [7:0]  FUSE_EXT_ADDR    = 8'h04;
   localparam logic [7:0]  STATUS_ADDR      = 8'h05;

   localparam int unsigned CLEAR_PAGE_BUFFER_BIT_POS         = 4;
   localparam int unsigned READ_FUSE_LOCK_BIT_POS         = 3;
   localparam int unsigned PAGE_WRITE_BIT_POS        = 2;
   localparam int unsigned PAGE_ERASE_BIT_POS        = 1;
   localparam int unsigned STORE_PROG_ENABLE_BIT_POS        = 0;
   localparam int unsigned SELFPROG_POS     = 0;
   localparam int unsigned DEBUG_POS        = 6;

   localparam logic [4:0]  CMD_CLEAR        = 5'h11;
   localparam logic [4:0]  CMD_READ_FL      = 5'h09;
   localparam logic [4:0]  CMD_WRITE        = 5'h05;
   localparam logic [4:0]  CMD_ERASE        = 5'h03;
   localparam logic [4:0]  CMD_LOAD         = 5'h01;

   localparam logic [7:0]  LOCK_RESET       = 8'hFF;
   localparam logic [7:0]  FUSE_LO_RESET    = 8'h62;
   localparam logic [7:0]  FUSE_HI_RESET    = 8'hDF;
   localparam logic [7:0]  FUSE_EXT_RESET   = 8'hFF;

   localparam int unsigned PAGE_WORDS       = 32;
   localparam int unsigned WORD_BITS        = 5;
   localparam int unsigned PAGE_BITS        = 7;

   typedef struct packed {
      logic        store;
      logic        load;
      logic [15:0] pointer;
      logic [15:0] data_pair;
   } spfc_cpu_req_t;

   typedef struct packed {
      logic        req;
      logic        erase;
      logic [6:0]  page;
   } spfc_flash_cmd_t;
endpackage : spfc_pkg

// ---- spfc_ctrl.sv ----
// Self-programming flash sequencer with page buffer, op timer and lock protection.
//////////////////////////////////////////////////////////////////////
module spfc_ctrl (
   input  wire logic                     mclk,
   input  wire logic                     rst_n,
   input  wire logic [7:0]               reg_addr,
   input  wire logic [7:0]               reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic [7:0]                    reg_rdata,
   input  wire spfc_pkg::spfc_cpu_req_t  cpu_req,
   input  wire logic                     eeprom_busy,
   input  wire logic                     chip_erase,
   input  wire logic                     lock_prog,
   input  wire logic [1:0]               lock_prog_val,
   output logic                          cpu_stall,
   output logic                          fuse_read_valid,
   output logic [7:0]                    fuse_read_data,
   output spfc_pkg::spfc_flash_cmd_t     flash_cmd,
   output logic [15:0]                   flash_wdata [spfc_pkg::PAGE_WORDS],
   output logic                          ext_prog_block,
   output logic                          ext_verify_block,
   output logic                          fuse_locked,
   output logic                          debug_read_allow
);

   typedef enum logic [3:0] {
      SPFC_IDLE  = 4'b0001,
      SPFC_ARMED = 4'b0010,
      SPFC_BUSY  = 4'b0100,
      SPFC_DONE  = 4'b1000
   } spfc_state_t;

   spfc_state_t  state_q;
   logic [4:0]   ctrl_q;
   logic [2:0]   win_q;
   logic [31:0]  op_cnt_q;
   logic         op_erase_q;
   logic [7:0]   lock_q;
   logic [7:0]   fuse_lo_q;
   logic [7:0]   fuse_hi_q;
   logic [7:0]   fuse_ext_q;
   logic [15:0]  buf_q [spfc_pkg::PAGE_WORDS];
   logic [15:0]  page_ptr_q;
   spfc_pkg::spfc_flash_cmd_t flash_cmd_q;
   logic         fr_valid_q;
   logic [7:0]   fr_data_q;
   logic [7:0]   rdata_q;
   logic         csr_wr;
   logic         cmd_ok;
   logic         self_prog_ok;
   logic         busy;
   logic         store_go;
   logic         load_go;
   logic         csr_take;
   logic         op_start;
   logic         arm_end;
   logic         op_end;
   logic         rst_late_q;

   assign busy         = (state_q == SPFC_BUSY);
   assign self_prog_ok = ~fuse_ext_q[spfc_pkg::SELFPROG_POS];
   assign csr_wr       = reg_wr && (reg_addr == spfc_pkg::CSR_ADDR);
   always_comb begin
      case (reg_wdata[4:0])
         spfc_pkg::CMD_CLEAR:   cmd_ok = 1'b1;
         spfc_pkg::CMD_READ_FL: cmd_ok = 1'b1;
         spfc_pkg::CMD_WRITE:   cmd_ok = 1'b1;
         spfc_pkg::CMD_ERASE:   cmd_ok = 1'b1;
         spfc_pkg::CMD_LOAD:    cmd_ok = 1'b1;
         default:               cmd_ok = 1'b0;
      endcase
   end
   assign store_go = (state_q == SPFC_ARMED) && cpu_req.store && self_prog_ok && !eeprom_busy &&
                     (ctrl_q[spfc_pkg::READ_FUSE_LOCK_BIT_POS] == 1'b0);
   assign load_go  = (state_q == SPFC_ARMED) && cpu_req.load && ctrl_q[spfc_pkg::READ_FUSE_LOCK_BIT_POS] &&
                     (win_q < 3'(spfc_pkg::LPM_WINDOW)) && !eeprom_busy;
   assign csr_take = (state_q == SPFC_IDLE) && csr_wr && cmd_ok && !eeprom_busy;
   assign op_start = store_go && (ctrl_q[spfc_pkg::PAGE_WRITE_BIT_POS] || ctrl_q[spfc_pkg::PAGE_ERASE_BIT_POS]);
   assign arm_end  = (state_q == SPFC_ARMED) && !op_start &&
                     (store_go || load_go || (win_q == 3'(spfc_pkg::SPM_WINDOW - 1)));
   assign op_end   = busy && (op_cnt_q == 32'(spfc_pkg::OP_MIN_CYC - 1));

   //////////////////////////////////////////////////////////////////////
   // Command state machine. A running operation ignores reset so it completes.
   always_ff @(posedge mclk) begin
      if (!rst_n && !busy) begin
         state_q <= SPFC_IDLE;
      end else begin
         case (state_q)
            SPFC_IDLE: begin
               if (csr_take) begin
                  state_q <= SPFC_ARMED;
               end
            end
            SPFC_ARMED: begin
               if (op_start) begin
                  state_q <= SPFC_BUSY;
               end else if (arm_end) begin
                  state_q <= SPFC_IDLE;
               end
            end
            SPFC_BUSY: begin
               if (op_end) begin
                  state_q <= SPFC_DONE;
               end
            end
            SPFC_DONE: begin
               state_q <= SPFC_IDLE;
            end
            default: begin
               state_q <= SPFC_IDLE;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Command bits. Nothing clears them while busy, so software can poll them.
   // enable held busy
   always_ff @(posedge mclk) begin
      if (!rst_n && !busy) begin
         ctrl_q <= 5'h00;
      end else if (csr_take) begin
         ctrl_q <= reg_wdata[4:0];
      end else if (arm_end) begin
         ctrl_q <= 5'h00;
      end else if (state_q == SPFC_DONE) begin
         ctrl_q <= 5'h00;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n && !busy) begin
         win_q <= 3'h0;
      end else if (csr_take) begin
         win_q <= 3'h0;
      end else if (state_q == SPFC_ARMED) begin
         win_q <= win_q + 3'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n && !busy) begin
         op_erase_q <= 1'b0;
         page_ptr_q <= 16'h0000;
      end else if (op_start) begin
         op_erase_q <= ctrl_q[spfc_pkg::PAGE_ERASE_BIT_POS];
         page_ptr_q <= cpu_req.pointer;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Operation timer. The minimum time is used so the maximum is never reached.
   always_ff @(posedge mclk) begin
      if (busy) begin
         op_cnt_q <= op_cnt_q + 32'h1;
      end else begin
         op_cnt_q <= 32'h0;
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Temporary page buffer.
   always_ff @(posedge mclk) begin
      if ((!rst_n && !busy) || (state_q == SPFC_DONE && (!op_erase_q || rst_late_q)) ||
          (state_q == SPFC_ARMED && store_go && ctrl_q == spfc_pkg::CMD_CLEAR) ||
          eeprom_busy) begin
         for (int i = 0; i < spfc_pkg::PAGE_WORDS; i++) begin
            buf_q[i] <= 16'hFFFF;
         end
      end else if (store_go && ctrl_q == spfc_pkg::CMD_LOAD) begin
         buf_q[cpu_req.pointer[spfc_pkg::WORD_BITS:1]] <= cpu_req.data_pair;
      end
   end

   // A reset in mid-operation waits for the end, so the page being written keeps its data.
   always_ff @(posedge mclk) begin
      if (!busy) begin
         rst_late_q <= 1'b0;
      end else if (!rst_n) begin
         rst_late_q <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n && !busy) begin
         flash_cmd_q <= '0;
      end else begin
         flash_cmd_q.req   <= (state_q == SPFC_DONE);
         flash_cmd_q.erase <= op_erase_q;
         flash_cmd_q.page  <= page_ptr_q[spfc_pkg::WORD_BITS + spfc_pkg::PAGE_BITS:spfc_pkg::WORD_BITS + 1];
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Lock and fuse storage. Fuses are held as loadable registers here.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fuse_lo_q  <= spfc_pkg::FUSE_LO_RESET;
         fuse_hi_q  <= spfc_pkg::FUSE_HI_RESET;
         fuse_ext_q <= spfc_pkg::FUSE_EXT_RESET;
      end else if (reg_wr && !fuse_locked) begin
         if (reg_addr == spfc_pkg::FUSE_LO_ADDR) begin
            fuse_lo_q <= reg_wdata;
         end
         if (reg_addr == spfc_pkg::FUSE_HI_ADDR) begin
            fuse_hi_q <= reg_wdata;
         end
         if (reg_addr == spfc_pkg::FUSE_EXT_ADDR) begin
            fuse_ext_q <= reg_wdata;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lock_q <= spfc_pkg::LOCK_RESET;
      end else if (chip_erase) begin
         lock_q <= spfc_pkg::LOCK_RESET;
      end else if (lock_prog) begin
         lock_q <= {6'h3F, lock_q[1:0] & lock_prog_val};
      end
   end

   always_comb begin
      case (lock_q[1:0])
         2'b11: begin
            ext_prog_block   = 1'b0;
            ext_verify_block = 1'b0;
         end
         2'b10: begin
            ext_prog_block   = 1'b1;
            ext_verify_block = 1'b0;
         end
         2'b00: begin
            ext_prog_block   = 1'b1;
            ext_verify_block = 1'b1;
         end
         // Only the high bit programmed is no listed mode; it is treated like mode two.
         default: begin
            ext_prog_block   = 1'b1;
            ext_verify_block = 1'b0;
         end
      endcase
   end
   assign fuse_locked      = ~lock_q[0];
   assign debug_read_allow = ~fuse_hi_q[spfc_pkg::DEBUG_POS] || !ext_verify_block;

   //////////////////////////////////////////////////////////////////////
   // Fuse and lock readback for the load instruction.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         fr_valid_q <= 1'b0;
         fr_data_q  <= 8'h00;
      end else begin
         fr_valid_q <= load_go;
         if (load_go) begin
            case (cpu_req.pointer[1:0])
               2'b00: begin
                  fr_data_q <= fuse_lo_q;
               end
               2'b01: begin
                  fr_data_q <= lock_q;
               end
               2'b10: begin
                  fr_data_q <= fuse_ext_q;
               end
               default: begin
                  fr_data_q <= fuse_hi_q;
               end
            endcase
         end
      end
   end

   //////////////////////////////////////////////////////////////////////
   // Register read port.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            spfc_pkg::CSR_ADDR: begin
               rdata_q <= {3'h0, ctrl_q[4:1], ctrl_q[0] | busy};
            end
            spfc_pkg::LOCK_ADDR: begin
               rdata_q <= lock_q;
            end
            spfc_pkg::FUSE_LO_ADDR: begin
               rdata_q <= fuse_lo_q;
            end
            spfc_pkg::FUSE_HI_ADDR: begin
               rdata_q <= fuse_hi_q;
            end
            spfc_pkg::FUSE_EXT_ADDR: begin
               rdata_q <= fuse_ext_q;
            end
            spfc_pkg::STATUS_ADDR: begin
               rdata_q <= {7'h00, busy};
            end
            default: begin
               rdata_q <= 8'h00;
            end
         endcase
      end
   end

   assign cpu_stall        = busy;
   assign reg_rdata        = rdata_q;
   assign fuse_read_valid  = fr_valid_q;
   assign fuse_read_data   = fr_data_q;
   assign flash_cmd        = flash_cmd_q;
   assign flash_wdata      = buf_q;

endmodule : spfc_ctrl

// ---- spfc_ctrl_asserts.sv ----
// Port checker for the self-programming flash control block.
module spfc_chk (
   input wire logic                    mclk,
   input wire logic                    rst_n,
   input wire logic [7:0]              reg_addr,
   input wire logic [7:0]              reg_wdata,
   input wire logic                    reg_wr,
   input wire logic                    reg_rd,
   input wire logic [7:0]              reg_rdata,
   input wire spfc_pkg::spfc_cpu_req_t cpu_req,
   input wire logic                    eeprom_busy,
   input wire logic                    chip_erase,
   input wire logic                    lock_prog,
   input wire logic [1:0]              lock_prog_val,
   input wire logic                    cpu_stall,
   input wire logic                    fuse_read_valid,
   input wire logic                    ext_prog_block,
   input wire logic                    ext_verify_block,
   input wire logic                    fuse_locked
);
   logic [7:0]  lk_q;
   logic [31:0] cnt_q;
   // Shadow of the lock byte, so protection outputs can be judged.
   always_ff @(posedge mclk) begin
      if (!rst_n || chip_erase) lk_q <= 8'hFF;
      else if (lock_prog) lk_q <= lk_q & {6'h3F, lock_prog_val};
   end
   // The count ignores reset because a running operation outlives it.
   always_ff @(posedge mclk) begin
      if (!cpu_stall) cnt_q <= 32'h0;
      else cnt_q <= cnt_q + 32'h1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   ////////////////////
   sequence s_rd_cmd;
      reg_wr && reg_addr == spfc_pkg::CSR_ADDR && reg_wdata[4:0] == spfc_pkg::CMD_READ_FL;
   endsequence
   sequence s_late_load;
      !cpu_req.load [*3] ##1 cpu_req.load;
   endsequence
   a_rsv_bits_zero: assert property (reg_rd && reg_addr == spfc_pkg::CSR_ADDR |=> reg_rdata[7:5] == 3'h0)
      else $error("reserved control bits read nonzero");
   a_stall_cause: assert property ($rose(cpu_stall) |-> $past(cpu_req.store))
      else $error("stall began without a store");
   a_op_min_len: assert property ($fell(cpu_stall) |-> cnt_q >= spfc_pkg::OP_MIN_CYC - 1)
      else $error("operation ended too early");
   a_op_max_len: assert property (cpu_stall |-> cnt_q < spfc_pkg::OP_MAX_CYC)
      else $error("operation ran too long");
   a_mode_two: assert property (ext_prog_block == (lk_q[1:0] != 2'b11) && fuse_locked == !lk_q[0])
      else $error("programming block wrong for lock bits");
   a_mode_three: assert property (ext_verify_block == (lk_q[1:0] == 2'b00))
      else $error("verify block wrong for lock bits");
   a_fuse_pulse: assert property (fuse_read_valid |-> $past(cpu_req.load))
      else $error("fuse data without a load");
   a_load_expiry: assert property (s_rd_cmd ##1 s_late_load |=> !fuse_read_valid)
      else $error("late load still read fuses");
   a_eeprom_block: assert property (eeprom_busy && cpu_req.load |=> !fuse_read_valid)
      else $error("fuse read during eeprom write");
endmodule : spfc_chk

bind spfc_ctrl spfc_chk chk_u (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_req,
   .eeprom_busy, .chip_erase, .lock_prog, .lock_prog_val, .cpu_stall, .fuse_read_valid, .ext_prog_block,
   .ext_verify_block, .fuse_locked);

// ---- spfc_cpu_model.sv ----
// Behavioural CPU core issuing store and load program requests.
module spfc_cpu_model (
   input  wire logic              mclk,
   input  wire logic              go_store,
   input  wire logic              go_load,
   input  wire logic [15:0]       ptr,
   input  wire logic [15:0]       dat,
   input  wire logic              cpu_stall,
   output spfc_pkg::spfc_cpu_req_t cpu_req
);
   logic [15:0] scr_q = 16'hA5C3;
   // Idle operand lines wander so that a stale value never looks valid.
   always_ff @(posedge mclk) begin
      scr_q <= {scr_q[14:0], scr_q[15] ^ scr_q[13]};
   end
   always_comb begin
      cpu_req.store     = go_store & ~cpu_stall;
      cpu_req.load      = go_load & ~cpu_stall;
      cpu_req.pointer   = (go_store | go_load) ? ptr : scr_q;
      cpu_req.data_pair = go_store ? dat : ~scr_q;
   end
endmodule : spfc_cpu_model

// ---- spfc_ctrl_tb_top.sv ----
// Self-checking bench for the self-programming flash control block.
module spfc_ctrl_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic                      mclk, rst_n, reg_wr, reg_rd, go_st, go_ld, ee_busy, chip_erase, lock_prog;
   logic                      cpu_stall, fuse_read_valid, ext_prog_block, ext_verify_block, fuse_locked, dbg_ok;
   logic [1:0]                lock_prog_val, v;
   logic [7:0]                reg_addr, reg_wdata, reg_rdata, fuse_read_data, rv;
   logic [7:0]                lexp = 8'hFF;
   logic [7:0]                extv = 8'hFF;
   logic [15:0]               ptr, dat, exp_buf [32], flash_wdata [spfc_pkg::PAGE_WORDS];
   logic [31:0]               r;
   logic [31:0]               rng = 32'h8B8036DD;
   int                        fails = 0, n_checks = 0;
   spfc_pkg::spfc_cpu_req_t   cpu_req;
   spfc_pkg::spfc_flash_cmd_t flash_cmd;
   localparam logic [7:0]     CSR = spfc_pkg::CSR_ADDR;
   localparam logic [7:0]     BAD [5] = '{8'h07, 8'h1F, 8'h13, 8'h00, 8'h10};
   localparam int             FMAP [4] = '{2, 1, 4, 3};
   spfc_ctrl dut_u (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_req,
      .eeprom_busy(ee_busy), .chip_erase, .lock_prog, .lock_prog_val, .cpu_stall, .fuse_read_valid,
      .fuse_read_data, .flash_cmd, .flash_wdata, .ext_prog_block, .ext_verify_block, .fuse_locked,
      .debug_read_allow(dbg_ok));
   spfc_cpu_model cpu_u (.mclk, .go_store(go_st), .go_load(go_ld), .ptr, .dat, .cpu_stall, .cpu_req);
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   ////////////////////
   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction : xs
   function automatic logic [7:0] fexp(input int a);
      case (a)
         1: return lexp;
         2: return spfc_pkg::FUSE_LO_RESET;
         3: return spfc_pkg::FUSE_HI_RESET;
         default: return extv;
      endcase
   endfunction : fexp
   function automatic logic [2:0] mode_exp(input logic [1:0] l);
      return {l != 2'b11, l == 2'b00, l != 2'b11};
   endfunction : mode_exp
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic chk_buf();
      for (int i = 0; i < 32; i++) chk(flash_wdata[i], exp_buf[i]);
   endtask : chk_buf
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask : rd
   task automatic op(input logic l, input logic [15:0] p, input logic [15:0] d);
      go_st <= !l;
      go_ld <= l;
      ptr <= p;
      dat <= d;
      @(posedge mclk);
      go_st <= 1'b0;
      go_ld <= 1'b0;
      #1;
   endtask : op
   task automatic lk(input logic ce, input logic [1:0] lv);
      chip_erase <= ce;
      lock_prog <= !ce;
      lock_prog_val <= lv;
      @(posedge mclk);
      chip_erase <= 1'b0;
      lock_prog <= 1'b0;
      #1;
   endtask : lk
   task automatic rst_pulse();
      rst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      #1;
      foreach (exp_buf[i]) exp_buf[i] = 16'hFFFF;
      extv = 8'hFF;
   endtask : rst_pulse
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : summarize
   ////////////////////
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      summarize();
   end
   initial begin
      {reg_wr, reg_rd, go_st, go_ld, ee_busy, chip_erase, lock_prog} = '0;
      {reg_addr, reg_wdata, ptr, dat, lock_prog_val} = '0;
      rst_pulse();
      for (int a = 1; a < 5; a++) begin
         rd(8'(a));
         chk(rv, fexp(a));
      end
      rd(8'h20);
      chk(rv, 8'h00);
      wr(CSR, 8'h01);
      op(1'b0, 16'h0000, 16'h1234);
      chk_buf();
      wr(spfc_pkg::FUSE_EXT_ADDR, 8'hFE);
      extv = 8'hFE;
      // Let the refused store's window run out, so the next command is taken.
      repeat (4) @(posedge mclk);
      // The fifth delay lands one cycle past the store window.
      for (int d = 0; d < 5; d++) begin
         r = xs();
         wr(CSR, 8'hE1);
         repeat (d) @(posedge mclk);
         op(1'b0, {r[31:22], 5'(8 + d), r[16]}, r[15:0]);
         if (d < 4) exp_buf[8 + d] = r[15:0];
         rd(CSR);
         chk(rv, 8'h00);
      end
      chk_buf();
      for (int i = 0; i < 8; i++) begin
         r = xs();
         wr(CSR, 8'h01);
         op(1'b0, {r[31:22], 5'(i), r[16]}, r[15:0]);
         exp_buf[i] = r[15:0];
      end
      chk_buf();
      foreach (BAD[k]) begin
         wr(CSR, BAD[k]);
         op(1'b0, 16'h0028, 16'h0BAD);
      end
      chk_buf();
      rst_pulse();
      chk_buf();
      wr(spfc_pkg::FUSE_EXT_ADDR, 8'hFE);
      extv = 8'hFE;
      wr(CSR, 8'h01);
      op(1'b0, 16'h0042, 16'hC0DE);
      wr(CSR, {3'h0, spfc_pkg::CMD_CLEAR});
      op(1'b0, 16'h0000, 16'h0000);
      chk_buf();
      ee_busy <= 1'b1;
      wr(CSR, 8'h01);
      op(1'b0, 16'h0002, 16'h5555);
      wr(CSR, {3'h0, spfc_pkg::CMD_READ_FL});
      op(1'b1, 16'h0001, 16'h0000);
      chk(fuse_read_valid, 1'b0);
      chk_buf();
      ee_busy <= 1'b0;
      wr(spfc_pkg::FUSE_HI_ADDR, 8'h9F);
      chk(dbg_ok, 1'b1);
      for (int j = 0; j < 4; j++) begin
         wr(CSR, {3'h0, spfc_pkg::CMD_READ_FL});
         op(1'b1, 16'(j), 16'h0000);
         chk(fuse_read_valid, 1'b1);
         chk(fuse_read_data, j == 3 ? 8'h9F : fexp(FMAP[j]));
      end
      wr(CSR, {3'h0, spfc_pkg::CMD_READ_FL});
      repeat (3) @(posedge mclk);
      op(1'b1, 16'h0001, 16'h0000);
      chk(fuse_read_valid, 1'b0);
      for (int m = 0; m < 3; m++) begin
         v = (m == 0) ? 2'b10 : 2'b01;
         lk(m == 2, v);
         lexp = (m == 2) ? 8'hFF : lexp & {6'h3F, v};
         rd(spfc_pkg::LOCK_ADDR);
         chk(rv, lexp);
         chk({ext_prog_block, ext_verify_block, fuse_locked, dbg_ok}, {mode_exp(lexp[1:0]), 1'b1});
      end
      wr(CSR, {3'h0, spfc_pkg::CMD_ERASE});
      op(1'b0, 16'h0FC0, 16'hFFFF);
      chk(cpu_stall, 1'b1);
      rd(CSR);
      chk(rv[1:0], 2'b11);
      rst_pulse();
      chk(cpu_stall, 1'b1);
      repeat (1000) @(posedge mclk);
      #1;
      chk({cpu_stall, flash_cmd.req}, 2'b10);
      summarize();
   end
endmodule : spfc_ctrl_tb_top
